// >>> crs_alu.sv
// Fourteen-bit register arithmetic and logic unit, purely combinational.
// Assumes the caller qualifies the result with the hit flag and the condition.
`timescale 1ns/1ps
module crs_alu (
  // Operation
  input wire logic [7:0] op,
  input wire logic [crs_pkg::ALU_W-1:0] a,
  input wire logic [crs_pkg::ALU_W-1:0] b,
  // Result
  output logic [crs_pkg::ALU_W-1:0] y,
  output logic hit
);
  always_comb begin
    y = a;
    hit = 1'b1;
    case (op)
      crs_pkg::OP_ADD: y = a + b;
      crs_pkg::OP_SUB: y = a - b;
      crs_pkg::OP_OR: y = a | b;
      crs_pkg::OP_AND: y = a & b;
      crs_pkg::OP_XOR: y = a ^ b;
      crs_pkg::OP_NOR: y = ~(a | b);
      crs_pkg::OP_NAND: y = ~(a & b);
      crs_pkg::OP_MIN: y = (a < b) ? a : b;
      crs_pkg::OP_MAX: y = (a > b) ? a : b;
      default: hit = 1'b0;
    endcase
  end
endmodule // crs_alu

// >>> crs_exec_top.sv
// Executor for stack, register arithmetic and buffer shift-by-register instructions.
// Assumes the instruction source and buffer loader run on mclk.
`timescale 1ns/1ps
module crs_exec_top #(
  parameter int BUF_WORDS = 512
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Instruction queue
  input wire logic instr_valid,
  input wire logic [31:0] instruction_word,
  output logic instr_ready_q,
  output logic instr_done_q,
  // Buffer load and observe
  input wire logic buf_wr_en,
  input wire logic [$clog2(BUF_WORDS)-1:0] buf_addr,
  input wire logic [31:0] buf_wdata,
  output logic [31:0] buf_rdata_q,
  // Register observe
  input wire logic [3:0] reg_sel,
  output logic [15:0] obs_data_q,
  output logic [15:0] obs_size_q,
  // Status
  output logic carry_q
);
  localparam int AW = $clog2(BUF_WORDS);

  crs_pkg::crs_state_e state_q;
  logic [31:0] iw_q;
  logic [3:0] cnt_q;
  logic [15:0] pos_q;
  logic [15:0] reg_data_q [16];
  logic [15:0] reg_size_q [16];
  logic [31:0] operand_memory_buffer [BUF_WORDS];

  logic [7:0] opc;
  logic [3:0] condition_field;
  assign opc = iw_q[crs_pkg::OPC_MSB:crs_pkg::OPC_LSB];
  assign condition_field = iw_q[crs_pkg::COND_MSB:crs_pkg::COND_LSB];
  logic [3:0] dst_idx;
  logic [3:0] src1_idx;
  logic [3:0] src0_idx;
  assign dst_idx = iw_q[crs_pkg::DST_MSB:crs_pkg::DST_LSB];
  assign src1_idx = iw_q[crs_pkg::SRC1_MSB:crs_pkg::SRC1_LSB];
  assign src0_idx = iw_q[crs_pkg::SRC0_MSB:crs_pkg::SRC0_LSB];

  logic [15:0] first_source_operand;
  logic [15:0] second_source_operand;
  logic [15:0] stack_pointer_register;
  logic [15:0] src_size;
  logic [15:0] dst_size;
  logic [15:0] dst_base;
  assign first_source_operand = reg_data_q[src1_idx];
  assign second_source_operand = reg_data_q[src0_idx];
  assign stack_pointer_register = reg_data_q[crs_pkg::REG_SP];
  assign src_size = reg_size_q[src1_idx];
  assign dst_size = reg_size_q[dst_idx];
  assign dst_base = reg_data_q[dst_idx];

  logic cond_ok;
  assign cond_ok = (condition_field == crs_pkg::COND_ALWAYS) ||
                   ((condition_field == crs_pkg::COND_CARRY_SET) && carry_q) ||
                   ((condition_field == crs_pkg::COND_CARRY_CLR) && !carry_q);

  logic is_shl;
  logic is_shr;
  logic exec_go;
  assign is_shl = (opc == crs_pkg::OP_BUFFER_SHIFT_LEFT_BY_REG);
  assign is_shr = (opc == crs_pkg::OP_BUFFER_SHIFT_RIGHT_BY_REG);
  assign exec_go = (state_q == crs_pkg::ST_EXEC) && cond_ok;

  logic [crs_pkg::ALU_W-1:0] alu_y;
  logic alu_hit;
  crs_alu u_alu (
    .op(opc),
    .a(first_source_operand[crs_pkg::ALU_W-1:0]),
    .b(second_source_operand[crs_pkg::ALU_W-1:0]),
    .y(alu_y),
    .hit(alu_hit)
  );

  // Reads one bit of a buffer operand; the operand is bit-addressed from a word base.
  function automatic logic buffer_read(input logic [15:0] base, input logic [16:0] pos);
    logic [AW-1:0] wa;
    wa = AW'(int'(base) + int'(pos[15:5]));
    return operand_memory_buffer[wa][pos[4:0]];
  endfunction

  logic [crs_pkg::SHAMT_W-1:0] shamt;
  logic shamt_nz;
  assign shamt = second_source_operand[crs_pkg::SHAMT_W-1:0];
  assign shamt_nz = (second_source_operand[crs_pkg::ALU_W-1:0] != 14'h0000);

  // Bit-serial shift. Left shifts walk from the top bit down and right shifts from
  // bit zero up, so an operand shifted in place never reads a bit already rewritten.
  logic [16:0] src_pos;
  logic src_in;
  logic shift_bit;
  always_comb begin
    if (is_shl) begin
      src_pos = {1'b0, pos_q} - {5'h00, shamt};
      src_in = (pos_q >= {4'h0, shamt}) && (src_pos <= {1'b0, src_size});
    end else begin
      src_pos = {1'b0, pos_q} + {5'h00, shamt};
      src_in = (src_pos <= {1'b0, src_size});
    end
    shift_bit = src_in ? buffer_read(first_source_operand, src_pos) : 1'b0;
  end

  // Carry candidates sampled before the destination is modified.
  logic [16:0] cl_pos;
  logic [16:0] cr_pos;
  logic carry_new;
  always_comb begin
    cl_pos = {1'b0, dst_size} + 17'h00001 - {5'h00, shamt};
    cr_pos = {5'h00, shamt} - 17'h00001;
    carry_new = 1'b0;
    if (is_shl && (shamt != 12'h000) && ({5'h00, shamt} <= {1'b0, dst_size} + 17'h00001) &&
        (cl_pos <= {1'b0, src_size})) begin
      carry_new = buffer_read(first_source_operand, cl_pos);
    end else if (is_shr && (shamt != 12'h000) && (cr_pos <= {1'b0, src_size})) begin
      carry_new = buffer_read(first_source_operand, cr_pos);
    end
  end

  logic [AW-1:0] wr_addr;
  logic [AW-1:0] stk_addr;
  assign wr_addr = AW'(int'(dst_base) + int'(pos_q[15:5]));
  assign stk_addr = AW'(int'(stack_pointer_register) + int'(cnt_q));

  logic [31:0] pop_word;
  assign pop_word = operand_memory_buffer[stk_addr];

  // Sequencer.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= crs_pkg::ST_IDLE;
      instr_ready_q <= 1'b1;
      instr_done_q <= 1'b0;
      iw_q <= 32'h00000000;
      cnt_q <= 4'h0;
      pos_q <= 16'h0000;
    end else begin
      instr_done_q <= 1'b0;
      case (state_q)
        crs_pkg::ST_IDLE: begin
          if (instr_valid && instr_ready_q) begin
            iw_q <= instruction_word;
            instr_ready_q <= 1'b0;
            state_q <= crs_pkg::ST_EXEC;
          end
        end
        crs_pkg::ST_EXEC: begin
          cnt_q <= 4'h0;
          if (!cond_ok) begin
            state_q <= crs_pkg::ST_DONE;
          end else if (opc == crs_pkg::OP_PUSH) begin
            state_q <= crs_pkg::ST_PUSH;
          end else if (opc == crs_pkg::OP_POP) begin
            state_q <= crs_pkg::ST_POP;
          end else if (is_shl) begin
            pos_q <= dst_size;
            state_q <= crs_pkg::ST_SHIFT;
          end else if (is_shr) begin
            pos_q <= 16'h0000;
            state_q <= crs_pkg::ST_SHIFT;
          end else begin
            state_q <= crs_pkg::ST_DONE;
          end
        end
        crs_pkg::ST_PUSH, crs_pkg::ST_POP: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == crs_pkg::STACK_LAST) begin
            state_q <= crs_pkg::ST_DONE;
          end
        end
        crs_pkg::ST_SHIFT: begin
          if (is_shl) begin
            if (pos_q == 16'h0000) begin
              state_q <= crs_pkg::ST_DONE;
            end else begin
              pos_q <= pos_q - 16'h0001;
            end
          end else if (pos_q == dst_size) begin
            state_q <= crs_pkg::ST_DONE;
          end else begin
            pos_q <= pos_q + 16'h0001;
          end
        end
        crs_pkg::ST_DONE: begin
          instr_ready_q <= 1'b1;
          instr_done_q <= 1'b1;
          state_q <= crs_pkg::ST_IDLE;
        end
        default: state_q <= crs_pkg::ST_IDLE;
      endcase
    end
  end

  // Register file.
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        reg_data_q[i] <= crs_pkg::REG_RST;
        reg_size_q[i] <= crs_pkg::REG_RST;
      end
    end else begin
      if (exec_go && alu_hit) begin
        reg_data_q[dst_idx][crs_pkg::ALU_W-1:0] <= alu_y;
      end
      if (exec_go && (opc == crs_pkg::OP_PUSH)) begin
        reg_data_q[crs_pkg::REG_SP] <= stack_pointer_register - crs_pkg::STACK_SPAN;
      end
      if (state_q == crs_pkg::ST_POP) begin
        reg_data_q[cnt_q] <= pop_word[31:crs_pkg::WORD_DATA_LSB];
        reg_size_q[cnt_q] <= pop_word[crs_pkg::WORD_DATA_LSB-1:0];
        if (cnt_q == crs_pkg::STACK_LAST) begin
          reg_data_q[crs_pkg::REG_SP] <= stack_pointer_register + crs_pkg::STACK_SPAN;
        end
      end
    end
  end

  // Operand buffer; the loader port is only honoured while idle.
  always_ff @(posedge mclk) begin
    if (buf_wr_en && (state_q == crs_pkg::ST_IDLE)) begin
      operand_memory_buffer[buf_addr] <= buf_wdata;
    end
    if (state_q == crs_pkg::ST_PUSH) begin
      operand_memory_buffer[stk_addr] <= {reg_data_q[cnt_q], reg_size_q[cnt_q]};
    end
    if (state_q == crs_pkg::ST_SHIFT) begin
      operand_memory_buffer[wr_addr][pos_q[4:0]] <= shift_bit;
    end
  end

  // Carry flag.
  always_ff @(posedge mclk) begin
    if (rst) begin
      carry_q <= crs_pkg::CARRY_RST;
    end else if (exec_go && (is_shl || is_shr) && shamt_nz) begin
      carry_q <= carry_new;
    end
  end

  // Observation ports.
  always_ff @(posedge mclk) begin
    if (rst) begin
      buf_rdata_q <= 32'h00000000;
      obs_data_q <= 16'h0000;
      obs_size_q <= 16'h0000;
    end else begin
      buf_rdata_q <= operand_memory_buffer[buf_addr];
      obs_data_q <= reg_data_q[reg_sel];
      obs_size_q <= reg_size_q[reg_sel];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  word_capture_a: assert property (instr_valid && instr_ready_q |=>
    state_q == crs_pkg::ST_EXEC && iw_q == $past(instruction_word))
    else $error("instruction word not captured");
  cond_skip_a: assert property (state_q == crs_pkg::ST_EXEC && !cond_ok |=>
    state_q == crs_pkg::ST_DONE ##1 instr_ready_q && instr_done_q)
    else $error("false condition did not finish in two cycles");
  false_hold_a: assert property (state_q == crs_pkg::ST_EXEC && !cond_ok |=>
    $stable(carry_q) && (dst_base == $past(dst_base)) && $stable(stack_pointer_register))
    else $error("false condition changed state");
  push_sp_a: assert property (exec_go && opc == crs_pkg::OP_PUSH |=>
    stack_pointer_register == $past(stack_pointer_register) - 16'h000F ##15
    state_q == crs_pkg::ST_DONE)
    else $error("push pointer or length wrong");
  pop_sp_a: assert property (state_q == crs_pkg::ST_POP && cnt_q == crs_pkg::STACK_LAST |=>
    stack_pointer_register == $past(stack_pointer_register) + 16'h000F)
    else $error("pop pointer not advanced");
  pop_load_a: assert property (state_q == crs_pkg::ST_POP && cnt_q != crs_pkg::STACK_LAST |=>
    reg_data_q[$past(cnt_q)] == $past(pop_word[31:16]) &&
    reg_size_q[$past(cnt_q)] == $past(pop_word[15:0]))
    else $error("pop reload wrong");
  add_value_a: assert property (exec_go && opc == crs_pkg::OP_ADD |=>
    reg_data_q[$past(dst_idx)][13:0] ==
    14'($past(first_source_operand[13:0]) + $past(second_source_operand[13:0])))
    else $error("add result wrong");
  nor_value_a: assert property (exec_go && opc == crs_pkg::OP_NOR |=>
    reg_data_q[$past(dst_idx)][13:0] ==
    ~($past(first_source_operand[13:0]) | $past(second_source_operand[13:0])))
    else $error("nor result wrong");
  min_value_a: assert property (exec_go && opc == crs_pkg::OP_MIN |=>
    reg_data_q[$past(dst_idx)][13:0] ==
    (($past(first_source_operand[13:0]) < $past(second_source_operand[13:0])) ?
    $past(first_source_operand[13:0]) : $past(second_source_operand[13:0])))
    else $error("min result wrong");
  carry_keep_a: assert property (exec_go && (is_shl || is_shr) && !shamt_nz |=>
    $stable(carry_q))
    else $error("carry changed on zero amount");
  carry_load_a: assert property (exec_go && (is_shl || is_shr) && shamt_nz |=>
    carry_q == $past(carry_new))
    else $error("carry not loaded");
  shift_write_a: assert property (state_q == crs_pkg::ST_SHIFT |=>
    operand_memory_buffer[$past(wr_addr)][$past(pos_q[4:0])] == $past(shift_bit))
    else $error("shifted bit not written");

  push_seen_c: cover property (exec_go && opc == crs_pkg::OP_PUSH);
  pop_seen_c: cover property (state_q == crs_pkg::ST_POP && cnt_q == crs_pkg::STACK_LAST);
  shl_seen_c: cover property (exec_go && is_shl && shamt_nz);
  shr_seen_c: cover property (exec_go && is_shr && shamt_nz);
  skip_seen_c: cover property (state_q == crs_pkg::ST_EXEC && !cond_ok);
endmodule // crs_exec_top

// >>> crs_exec_top_tb_top.sv
// Self-checking bench for the stack, register arithmetic and buffer shift executor.
// Assumes the executor is loaded through its buffer port and observed through reg_sel.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module crs_exec_top_tb_top;
  localparam int BW = 64;
  logic mclk, rst, instr_valid, instr_ready_q, instr_done_q, buf_wr_en, carry_q;
  logic [31:0] instruction_word, buf_wdata, buf_rdata_q;
  logic [5:0] buf_addr;
  logic [3:0] reg_sel;
  logic [15:0] obs_data_q, obs_size_q;
  logic [15:0] d [15];
  logic [15:0] s [15];
  int failures = 0;
  int compares = 0;

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  crs_exec_top #(.BUF_WORDS(BW)) u_crs_exec_top (.mclk(mclk), .rst(rst),
    .instr_valid(instr_valid), .instruction_word(instruction_word),
    .instr_ready_q(instr_ready_q), .instr_done_q(instr_done_q), .buf_wr_en(buf_wr_en),
    .buf_addr(buf_addr), .buf_wdata(buf_wdata), .buf_rdata_q(buf_rdata_q),
    .reg_sel(reg_sel), .obs_data_q(obs_data_q), .obs_size_q(obs_size_q), .carry_q(carry_q));
  crs_issuer u_crs_issuer (.mclk(mclk), .instr_ready_q(instr_ready_q),
    .instr_done_q(instr_done_q), .instr_valid(instr_valid),
    .instruction_word(instruction_word));

  task automatic end_sim();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr_buf(input logic [5:0] a, input logic [31:0] w);
    @(posedge mclk);
    #1;
    buf_wr_en = 1'b1;
    buf_addr = a;
    buf_wdata = w;
    @(posedge mclk);
    #1;
    buf_wr_en = 1'b0;
  endtask

  task automatic rd_buf(input logic [5:0] a, output logic [31:0] w);
    @(posedge mclk);
    #1;
    buf_addr = a;
    @(posedge mclk);
    #1;
    w = buf_rdata_q;
  endtask

  task automatic chk_reg(input logic [3:0] i, input logic [15:0] ed, input logic [15:0] es);
    @(posedge mclk);
    #1;
    reg_sel = i;
    @(posedge mclk);
    #1;
    `CHK("reg data", ed, obs_data_q)
    `CHK("reg size", es, obs_size_q)
  endtask

  task automatic run(input logic [31:0] w, input int exp_lat);
    int lat;
    u_crs_issuer.issue(w, lat);
    `CHK("latency", exp_lat, lat)
  endtask

  function automatic logic [13:0] alu_ref(input logic [7:0] op, input logic [13:0] a, b);
    case (op)
      crs_pkg::OP_ADD: return a + b;
      crs_pkg::OP_SUB: return a - b;
      crs_pkg::OP_OR: return a | b;
      crs_pkg::OP_AND: return a & b;
      crs_pkg::OP_XOR: return a ^ b;
      crs_pkg::OP_NOR: return ~(a | b);
      crs_pkg::OP_NAND: return ~(a & b);
      crs_pkg::OP_MIN: return (a < b) ? a : b;
      default: return (a > b) ? a : b;
    endcase
  endfunction

  task automatic t_reset();
    `CHK("ready", 1'b1, instr_ready_q)
    `CHK("done", 1'b0, instr_done_q)
    `CHK("carry", 1'b0, carry_q)
    chk_reg(4'hF, 16'h0000, 16'h0000);
  endtask

  task automatic t_pop();
    for (int k = 0; k < 15; k++) begin
      d[k] = 16'hC000 + 16'(k) * 16'h0111;
      s[k] = 16'(k);
    end
    d[1] = 16'h2A5C;
    d[2] = 16'h1F31;
    d[4] = 16'h0028;
    s[4] = 16'h000F;
    d[5] = 16'h0029;
    s[5] = 16'h000F;
    d[6] = 16'h0004;
    d[7] = 16'h0002;
    d[8] = 16'h4000;
    for (int k = 0; k < 15; k++) wr_buf(6'(k), {d[k], s[k]});
    run({crs_pkg::OP_POP, crs_pkg::COND_ALWAYS, 20'h0_0000}, 17);
    for (int k = 0; k < 15; k++) chk_reg(4'(k), d[k], s[k]);
    chk_reg(4'hF, 16'h000F, 16'h0000);
  endtask

  task automatic t_alu();
    logic [7:0] ops [9] = '{crs_pkg::OP_ADD, crs_pkg::OP_SUB, crs_pkg::OP_OR,
      crs_pkg::OP_AND, crs_pkg::OP_XOR, crs_pkg::OP_NOR, crs_pkg::OP_NAND,
      crs_pkg::OP_MIN, crs_pkg::OP_MAX};
    logic [3:0] cond;
    for (int i = 0; i < 9; i++) begin
      cond = (i % 2 == 1) ? crs_pkg::COND_CARRY_CLR : crs_pkg::COND_ALWAYS;
      run({ops[i], cond, 12'h030, 8'h12}, 2);
      d[3] = {d[3][15:14], alu_ref(ops[i], d[1][13:0], d[2][13:0])};
      chk_reg(4'h3, d[3], s[3]);
    end
  endtask

  // Adds r1 and r2 into r3 under a condition; only a true condition may change r3.
  task automatic t_cond(input logic [3:0] cond, input logic hit);
    logic c;
    c = carry_q;
    run({crs_pkg::OP_ADD, cond, 12'h030, 8'h12}, 2);
    if (hit) d[3] = {d[3][15:14], d[1][13:0] + d[2][13:0]};
    chk_reg(4'h3, d[3], s[3]);
    `CHK("carry kept", c, carry_q)
  endtask

  task automatic t_shift(input logic [7:0] op, input logic [3:0] amt, input logic [31:0] ew,
      input logic ec);
    logic [31:0] w;
    run({op, crs_pkg::COND_ALWAYS, 12'h050, 4'h4, amt}, 18);
    rd_buf(6'd41, w);
    `CHK("shift word", ew, w)
    `CHK("shift carry", ec, carry_q)
  endtask

  task automatic t_push();
    logic [31:0] w;
    for (int k = 0; k < 15; k++) wr_buf(6'(k), 32'h5555_5555);
    run({crs_pkg::OP_PUSH, crs_pkg::COND_ALWAYS, 20'h0_0000}, 17);
    chk_reg(4'hF, 16'h0000, 16'h0000);
    for (int k = 0; k < 15; k++) begin
      rd_buf(6'(k), w);
      `CHK("stack word", {d[k], s[k]}, w)
    end
  endtask

  initial begin
    #50000;
    failures++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    buf_wr_en = 1'b0;
    buf_addr = 6'h00;
    buf_wdata = 32'h0000_0000;
    reg_sel = 4'h0;
    repeat (5) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_reset();
    t_pop();
    t_alu();
    t_cond(4'h3, 1'b0);
    wr_buf(6'd40, 32'h0000_9ABC);
    wr_buf(6'd41, 32'hFFFF_0000);
    t_shift(crs_pkg::OP_BUFFER_SHIFT_LEFT_BY_REG, 4'h6, 32'hFFFF_ABC0, 1'b1);
    t_shift(crs_pkg::OP_BUFFER_SHIFT_LEFT_BY_REG, 4'h8, 32'hFFFF_9ABC, 1'b1);
    t_cond(crs_pkg::COND_CARRY_SET, 1'b1);
    t_cond(crs_pkg::COND_CARRY_CLR, 1'b0);
    t_shift(crs_pkg::OP_BUFFER_SHIFT_RIGHT_BY_REG, 4'h7, 32'hFFFF_26AF, 1'b0);
    t_push();
    end_sim();
  end
endmodule // crs_exec_top_tb_top

// >>> crs_issuer.sv
// Processor-side model that offers instruction words to the executor.
// Assumes it shares mclk with the executor and that ready is a registered level.
`timescale 1ns/1ps
module crs_issuer (
  // Clock
  input wire logic mclk,
  // Executor status
  input wire logic instr_ready_q,
  input wire logic instr_done_q,
  // Offer
  output logic instr_valid,
  output logic [31:0] instruction_word
);
  initial begin
    instr_valid = 1'b0;
    instruction_word = 32'h0000_0000;
  end

  // Offers one word, holds it until taken, then counts edges until done shows.
  task automatic issue(input logic [31:0] w, output int lat);
    int n;
    n = 0;
    @(posedge mclk);
    #1;
    instr_valid = 1'b1;
    instruction_word = w;
    while (instr_ready_q !== 1'b1 && n < 100) begin
      @(posedge mclk);
      #1;
      n++;
    end
    @(posedge mclk);
    #1;
    instr_valid = 1'b0;
    // The word is not held once taken, so show its inverse rather than a stale copy.
    instruction_word = ~w;
    lat = 0;
    while (instr_done_q !== 1'b1 && lat < 100) begin
      @(posedge mclk);
      #1;
      lat++;
    end
  endtask
endmodule // crs_issuer

// >>> crs_pkg.sv
// Shared constants for the register, stack and buffer shift instruction executor.
// Assumes a single clock domain and 32-bit instruction words from a queue.
package crs_pkg;
  // Instruction word fields.
  localparam int OPC_MSB = 31;
  localparam int OPC_LSB = 24;
  localparam int COND_MSB = 23;
  localparam int COND_LSB = 20;
  localparam int DST_MSB = 15;
  localparam int DST_LSB = 12;
  localparam int SRC1_MSB = 7;
  localparam int SRC1_LSB = 4;
  localparam int SRC0_MSB = 3;
  localparam int SRC0_LSB = 0;
  // Operation codes.
  localparam logic [7:0] OP_ADD = 8'h06;
  localparam logic [7:0] OP_SUB = 8'h07;
  localparam logic [7:0] OP_OR = 8'h08;
  localparam logic [7:0] OP_AND = 8'h09;
  localparam logic [7:0] OP_XOR = 8'h0A;
  localparam logic [7:0] OP_NOR = 8'h0B;
  localparam logic [7:0] OP_NAND = 8'h0C;
  localparam logic [7:0] OP_MIN = 8'h0D;
  localparam logic [7:0] OP_MAX = 8'h0E;
  localparam logic [7:0] OP_PUSH = 8'h10;
  localparam logic [7:0] OP_POP = 8'h11;
  localparam logic [7:0] OP_BUFFER_SHIFT_LEFT_BY_REG = 8'h20;
  localparam logic [7:0] OP_BUFFER_SHIFT_RIGHT_BY_REG = 8'h23;
  // Condition field encodings.
  localparam logic [3:0] COND_ALWAYS = 4'h0;
  localparam logic [3:0] COND_CARRY_SET = 4'h1;
  localparam logic [3:0] COND_CARRY_CLR = 4'h2;
  // Stack layout.
  localparam logic [3:0] REG_SP = 4'hF;
  localparam logic [3:0] STACK_LAST = 4'hE;
  localparam logic [15:0] STACK_SPAN = 16'h000F;
  localparam int WORD_DATA_LSB = 16;
  // Operand widths and reset values.
  localparam int ALU_W = 14;
  localparam int SHAMT_W = 12;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic CARRY_RST = 1'b0;
  typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_PUSH, ST_POP, ST_SHIFT, ST_DONE} crs_state_e;
endpackage
